/* rtl/pswc_pkg.sv */
package pswc_pkg;
  localparam int          TUNE_W          = 4;
  localparam logic [15:0] TUNE_RESET      = 16'h0000;
  localparam logic [15:0] TUNE_FIELD_MASK = 16'h000F;
  localparam logic [3:0]  TUNE_MAX        = 4'h7;
  localparam logic [3:0]  TUNE_CENTRE     = 4'h0;
  localparam logic [3:0]  TUNE_MIN        = 4'h8;
  localparam int          CFG_COUNT       = 7;
  localparam int          CFG_W           = 24;
  localparam int          CFG_DATA_W      = 16;
  localparam logic [23:0] CFG_BASE        = 24'hF80000;
  localparam logic [23:0] CFG_LAST        = 24'hF8000C;
  localparam logic [23:0] OSC_CFG_ADDR    = 24'hF80000;
  localparam logic [23:0] WDT_CFG_ADDR    = 24'hF80002;
  localparam logic [23:0] BOR_CFG_ADDR    = 24'hF80004;
  localparam logic [23:0] BOOT_CFG_ADDR   = 24'hF80006;
  localparam logic [23:0] SEC_CFG_ADDR    = 24'hF80008;
  localparam logic [23:0] GEN_CFG_ADDR    = 24'hF8000A;
  localparam logic [23:0] DBG_CFG_ADDR    = 24'hF8000C;
  localparam logic [CFG_COUNT*24-1:0] CFG_DEFAULT = {CFG_COUNT{24'h00FFFF}};

  typedef enum logic [1:0] {
    PSWC_RUN   = 2'h0,
    PSWC_SLEEP = 2'h1,
    PSWC_IDLE  = 2'h2,
    PSWC_WAIT  = 2'h3
  } pswc_state_t;
endpackage : pswc_pkg

/* rtl/pswc_cfg_rom.sv */
`timescale 1ns/1ps
// Configuration word read port, one cycle latency
module pswc_cfg_rom
  import pswc_pkg::*;
#(
  parameter logic [CFG_COUNT*24-1:0] CFG_VALUES = CFG_DEFAULT
)
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        rd_en_in,
  input  wire logic [23:0] rd_addr_in,
  output logic             hit_out,
  output logic      [23:0] rd_data_out
);
  import pswc_pkg::*;

  logic [CFG_COUNT-1:0] sel;

  // Even addresses from base to last, one word each
  genvar g;
  generate
    for (g = 0; g < CFG_COUNT; g++)
    begin : g_dec
      assign sel[g] = (rd_addr_in == CFG_BASE + 24'(2 * g));
    end
  endgenerate

  assign hit_out = |sel;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_data_out <= 24'h000000;
    else if (rd_en_in)
    begin
      rd_data_out <= 24'h000000;
      for (int i = 0; i < CFG_COUNT; i++)
        if (sel[i])
          rd_data_out <= {8'h00, CFG_VALUES[i*24 +: CFG_DATA_W]};
    end
  end
endmodule : pswc_cfg_rom

/* rtl/pswc_ctrl.sv */
`timescale 1ns/1ps
// Function
// - Four-bit tuning field in bits 3..0, read/write, zero at power-on.
// - Tuning field is a signed step: 0 centre, 7 maximum, 8 minimum.
// - Tuning bits 15..4 read zero and ignore writes.
// - Sleep wakes on enabled, priority-qualified interrupt; sets sleep flag.
// - Oscillator dead after delays with monitor on: trap, switch to fast RC.
// - Oscillator dead with monitor off: stay asleep until clock starts.
// - Every reset wakes from sleep; non-power-on sets sleep flag, power-on clears.
// - Watchdog time-out in sleep wakes and sets sleep and watchdog flags.
// - Idle gates core clock; clock source keeps running, peripherals run unless stopped.
// - Peripheral idle-control bits decide whether each peripheral runs in idle.
// - Low-power RC fail-safe clock stays on in idle when monitor enabled.
// - Idle exits on qualified interrupt, power-on, brown-out, pin reset, watchdog.
// - Idle wake restores core clock and resumes at the next instruction.
// - Idle wake inserts no start-up delay.
// - Interrupt wake from idle is serviced and sets idle flag.
// - Non-power-on reset sets idle flag; power-on reset clears it.
// - Watchdog time-out in idle wakes and sets idle and watchdog flags.
// - Configuration words are 24 bits, only the lower 16 hold data.
// - Seven readable configuration words at even addresses F80000..F8000C.
module pswc_ctrl
  import pswc_pkg::*;
#(
  parameter int                      NUM_PERIPH = 8,
  parameter logic [CFG_COUNT*24-1:0] CFG_VALUES = CFG_DEFAULT
)
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  tune_wr_in,
  input  wire logic [15:0]           tune_wdata_in,
  output logic      [15:0]           tune_rdata_out,
  output logic signed [pswc_pkg::TUNE_W-1:0] tune_step_out,
  input  wire logic                  cfg_rd_in,
  input  wire logic [23:0]           cfg_addr_in,
  output logic      [23:0]           cfg_rdata_out,
  output logic                       cfg_hit_out,
  input  wire logic                  sleep_req_in,
  input  wire logic                  idle_req_in,
  input  wire logic                  irq_pending_in,
  input  wire logic                  irq_enable_in,
  input  wire logic                  irq_prio_ok_in,
  input  wire logic                  por_in,
  input  wire logic                  bor_in,
  input  wire logic                  pin_reset_in,
  input  wire logic                  other_reset_in,
  input  wire logic                  wdt_enable_in,
  input  wire logic                  wdt_timeout_in,
  input  wire logic                  startup_done_in,
  input  wire logic                  osc_running_in,
  input  wire logic                  fail_safe_clock_monitor_enable_in,
  input  wire logic                  xtal_reenable_in,
  input  wire logic [NUM_PERIPH-1:0] periph_idle_stop_in,
  input  wire logic                  flag_clr_sleep_in,
  input  wire logic                  flag_clr_idle_in,
  input  wire logic                  flag_clr_wdt_in,
  output logic                       core_clk_en_out,
  output logic [NUM_PERIPH-1:0]      periph_clk_en_out,
  output logic                       clk_src_en_out,
  output logic                       low_power_rc_oscillator_en_out,
  output logic                       use_frc_out,
  output logic                       clk_fail_trap_out,
  output logic                       irq_service_out,
  output logic                       sleep_flag_out,
  output logic                       idle_flag_out,
  output logic                       wdt_flag_out,
  output logic [1:0]                 state_out
);
  import pswc_pkg::*;

  pswc_state_t state;
  pswc_state_t next_state;
  logic [TUNE_W-1:0] tune_step;
  logic irq_wake;
  logic any_reset;
  logic soft_reset;
  logic osc_ok;
  logic wake_sleep_ev;
  logic wake_idle_ev;

  assign irq_wake   = irq_pending_in & irq_enable_in & irq_prio_ok_in;
  assign soft_reset = bor_in | pin_reset_in | other_reset_in;
  assign any_reset  = por_in | soft_reset;
  assign osc_ok     = osc_running_in & startup_done_in;

  // Tuning register
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      tune_step <= TUNE_RESET[TUNE_W-1:0];
    else if (por_in)
      tune_step <= TUNE_RESET[TUNE_W-1:0];
    else if (tune_wr_in)
      tune_step <= tune_wdata_in[TUNE_W-1:0];
  end

  assign tune_rdata_out = {12'h000, tune_step} & TUNE_FIELD_MASK;
  assign tune_step_out  = $signed(tune_step);

  // Power-save state machine
  always_comb
  begin
    next_state = state;
    case (state)
      PSWC_RUN:
        if (sleep_req_in)
          next_state = PSWC_SLEEP;
        else if (idle_req_in)
          next_state = PSWC_IDLE;
      PSWC_SLEEP:
        if (any_reset || irq_wake || (wdt_enable_in && wdt_timeout_in))
          next_state = PSWC_WAIT;
      PSWC_WAIT:
        if (osc_ok || (startup_done_in && fail_safe_clock_monitor_enable_in) || any_reset)
          next_state = PSWC_RUN;
      PSWC_IDLE:
        if (any_reset || irq_wake || (wdt_enable_in && wdt_timeout_in))
          next_state = PSWC_RUN;
      default:
        next_state = PSWC_RUN;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= PSWC_RUN;
    else
      state <= next_state;
  end

  assign wake_sleep_ev = (state == PSWC_SLEEP) && (next_state != PSWC_SLEEP);
  assign wake_idle_ev  = (state == PSWC_IDLE) && (next_state != PSWC_IDLE);

  // Core clock gated in sleep, idle and while waiting for oscillator
  assign core_clk_en_out = (state == PSWC_RUN);
  assign clk_src_en_out  = (state != PSWC_SLEEP);
  assign low_power_rc_oscillator_en_out     = fail_safe_clock_monitor_enable_in;

  // Peripherals run in idle unless their stop bit is set
  genvar p;
  generate
    for (p = 0; p < NUM_PERIPH; p++)
    begin : g_periph
      assign periph_clk_en_out[p] = (state == PSWC_RUN)
                                  || ((state == PSWC_IDLE) && !periph_idle_stop_in[p]);
    end
  endgenerate

  // Clock failure trap and fast RC fallback
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      use_frc_out       <= 1'b0;
      clk_fail_trap_out <= 1'b0;
    end
    else
    begin
      clk_fail_trap_out <= (state == PSWC_WAIT) && startup_done_in
                           && !osc_running_in && fail_safe_clock_monitor_enable_in;
      if ((state == PSWC_WAIT) && startup_done_in && !osc_running_in && fail_safe_clock_monitor_enable_in)
        use_frc_out <= 1'b1;
      else if (xtal_reenable_in)
        use_frc_out <= 1'b0;
    end
  end

  // Interrupt service request on wake
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_service_out <= 1'b0;
    else
      irq_service_out <= (wake_sleep_ev || wake_idle_ev) && irq_wake && !any_reset;
  end

  // Status flags, set wins over software clear
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sleep_flag_out <= 1'b0;
      idle_flag_out  <= 1'b0;
      wdt_flag_out   <= 1'b0;
    end
    else if (por_in)
    begin
      sleep_flag_out <= 1'b0;
      idle_flag_out  <= 1'b0;
      wdt_flag_out   <= 1'b0;
    end
    else
    begin
      if (wake_sleep_ev || soft_reset)
        sleep_flag_out <= 1'b1;
      else if (flag_clr_sleep_in)
        sleep_flag_out <= 1'b0;
      if ((wake_idle_ev && irq_wake) || soft_reset
          || (state == PSWC_IDLE && wdt_enable_in && wdt_timeout_in))
        idle_flag_out <= 1'b1;
      else if (flag_clr_idle_in)
        idle_flag_out <= 1'b0;
      if ((wake_sleep_ev || wake_idle_ev) && wdt_enable_in && wdt_timeout_in)
        wdt_flag_out <= 1'b1;
      else if (flag_clr_wdt_in)
        wdt_flag_out <= 1'b0;
    end
  end

  assign state_out = state;

  pswc_cfg_rom #(
    .CFG_VALUES (CFG_VALUES)
  ) u_cfg (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .rd_en_in    (cfg_rd_in),
    .rd_addr_in  (cfg_addr_in),
    .hit_out     (cfg_hit_out),
    .rd_data_out (cfg_rdata_out)
  );

  chk_tune_reads_masked: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tune_rdata_out[15:4] == 12'h000) else $error("tuning upper bits not zero");
  chk_tune_write_lands: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tune_wr_in && !por_in |=> tune_rdata_out == {12'h000, $past(tune_wdata_in[3:0])})
    else $error("tuning write lost");
  chk_sleep_irq_wake: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_SLEEP && irq_wake && !por_in |=> sleep_flag_out && state == PSWC_WAIT)
    else $error("sleep interrupt wake missing");
  chk_idle_fast_exit: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_IDLE && irq_wake && !por_in |=> core_clk_en_out && idle_flag_out)
    else $error("idle wake delayed");
  chk_por_clears_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
    por_in |=> !sleep_flag_out && !idle_flag_out) else $error("power-on left flags");
  chk_soft_reset_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
    soft_reset && !por_in |=> sleep_flag_out && idle_flag_out)
    else $error("reset flags not set");
  chk_wdt_sleep_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_SLEEP && wdt_enable_in && wdt_timeout_in && !por_in
    |=> wdt_flag_out && sleep_flag_out) else $error("watchdog wake flags");
  chk_wait_no_fail_safe_clock_monitor: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_WAIT && !osc_running_in && !fail_safe_clock_monitor_enable_in && !any_reset
    |=> state == PSWC_WAIT && !core_clk_en_out) else $error("ran without clock");
  chk_fail_safe_clock_monitor_trap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_WAIT && startup_done_in && !osc_running_in && fail_safe_clock_monitor_enable_in
    |=> clk_fail_trap_out && use_frc_out) else $error("clock failure trap missing");
  chk_idle_gating: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == PSWC_IDLE |-> !core_clk_en_out && clk_src_en_out)
    else $error("idle gating wrong");
endmodule : pswc_ctrl

/* testbench/pswc_osc_model.sv */
`timescale 1ns/1ps
// Crystal oscillator and start-up timer on the clock side of the core
module pswc_osc_model
  import pswc_pkg::*;
#(
  parameter int DLY = 6
)
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] state_in,
  input  wire logic       xtal_ok_in,
  output logic            startup_done_out,
  output logic            osc_running_out
);
  int cnt;
  // Start-up delays restart every time the core goes to sleep
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt <= 0;
    else if (state_in == PSWC_SLEEP)
      cnt <= 0;
    else if (cnt < DLY)
      cnt <= cnt + 1;
  end
  assign startup_done_out = (cnt >= DLY);
  // A slow crystal stays dead after the delays until the bench calls it healthy
  assign osc_running_out  = startup_done_out && xtal_ok_in;
endmodule : pswc_osc_model

/* testbench/power_save_wake_control_tb.sv */
`timescale 1ns/1ps
module power_save_wake_control_tb;
  import pswc_pkg::*;
  localparam int DLY = 6;
  // Upper bytes set so that the 16-bit data mask is visible
  localparam logic [CFG_COUNT*24-1:0] CFG_TB = {24'hC7E006, 24'hB6D005, 24'hA5C004,
    24'h94B003, 24'h83A002, 24'h729001, 24'h618000};
  logic core_clk_in = 1'b0, rst_in = 1'b1, tune_wr_in = 1'b0, cfg_rd_in = 1'b0;
  logic sleep_req_in = 1'b0, idle_req_in = 1'b0, irq_pending_in = 1'b0, irq_enable_in = 1'b0;
  logic irq_prio_ok_in = 1'b1, por_in = 1'b0, wdt_enable_in = 1'b0, wdt_timeout_in = 1'b0;
  logic fail_safe_clock_monitor_enable_in = 1'b0, xtal_reenable_in = 1'b0, xtal_ok = 1'b1;
  logic flag_clr_sleep_in = 1'b0, flag_clr_idle_in = 1'b0, flag_clr_wdt_in = 1'b0;
  logic startup_done_in, osc_running_in, cfg_hit_out, core_clk_en_out, clk_src_en_out;
  logic low_power_rc_oscillator_en_out, use_frc_out, clk_fail_trap_out, irq_service_out;
  logic sleep_flag_out, idle_flag_out, wdt_flag_out;
  logic [2:0]  rst_src = 3'h0;
  logic [7:0]  periph_idle_stop_in = 8'h00, periph_clk_en_out;
  logic [15:0] tune_wdata_in = 16'h0000, tune_rdata_out;
  logic [23:0] cfg_addr_in = 24'h000000, cfg_rdata_out;
  logic signed [3:0] tune_step_out;
  logic [1:0]  state_out;
  int          num_errors = 0;
  int          num_checks = 0;

  always #10 core_clk_in = ~core_clk_in;

  pswc_ctrl #(.CFG_VALUES(CFG_TB)) u_pswc_ctrl (.core_clk_in, .rst_in, .tune_wr_in,
    .tune_wdata_in, .tune_rdata_out,
    .tune_step_out, .cfg_rd_in, .cfg_addr_in, .cfg_rdata_out, .cfg_hit_out, .sleep_req_in,
    .idle_req_in, .irq_pending_in, .irq_enable_in, .irq_prio_ok_in, .por_in,
    .bor_in(rst_src[0]), .pin_reset_in(rst_src[1]), .other_reset_in(rst_src[2]),
    .wdt_enable_in, .wdt_timeout_in, .startup_done_in, .osc_running_in, .fail_safe_clock_monitor_enable_in,
    .xtal_reenable_in, .periph_idle_stop_in, .flag_clr_sleep_in, .flag_clr_idle_in,
    .flag_clr_wdt_in, .core_clk_en_out, .periph_clk_en_out, .clk_src_en_out, .low_power_rc_oscillator_en_out,
    .use_frc_out, .clk_fail_trap_out, .irq_service_out, .sleep_flag_out, .idle_flag_out,
    .wdt_flag_out, .state_out);

  pswc_osc_model #(.DLY(DLY)) u_pswc_osc_model (.core_clk_in, .rst_in, .state_in(state_out),
    .xtal_ok_in(xtal_ok), .startup_done_out(startup_done_in), .osc_running_out(osc_running_in));

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : tick

  task automatic flags(input logic [2:0] e);
    chk({21'h0, sleep_flag_out, idle_flag_out, wdt_flag_out}, {21'h0, e}, "sleep/idle/wdt flags");
  endtask : flags

  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 60 && state_out !== s; i++)
      tick(1);
    chk({22'h0, state_out}, {22'h0, s}, "state after bounded wait");
    if (state_out !== s)
      results();
  endtask : wait_st

  task automatic tw(input logic [15:0] d);
    tune_wr_in = 1'b1;
    tune_wdata_in = d;
    tick(1);
    tune_wr_in = 1'b0;
  endtask : tw

  task automatic cr(input logic [23:0] a);
    cfg_rd_in = 1'b1;
    cfg_addr_in = a;
    tick(1);
    cfg_rd_in = 1'b0;
  endtask : cr

  task automatic req(input bit sl);
    flag_clr_sleep_in = 1'b1;
    flag_clr_idle_in = 1'b1;
    flag_clr_wdt_in = 1'b1;
    tick(1);
    {flag_clr_sleep_in, flag_clr_idle_in, flag_clr_wdt_in} = 3'b000;
    flags(3'b000);
    if (sl)
      sleep_req_in = 1'b1;
    else
      idle_req_in = 1'b1;
    tick(1);
    {sleep_req_in, idle_req_in} = 2'b00;
    chk({22'h0, state_out}, sl ? 24'h1 : 24'h2, "power-save entry");
    chk({23'h0, clk_src_en_out}, sl ? 24'h0 : 24'h1, "clock source in power-save");
  endtask : req

  initial
  begin
    tick(4);
    rst_in = 1'b0;
    chk(tune_rdata_out, 24'h0, "tuning reset");
    flags(3'b000);
    tw(16'h0037);
    chk(tune_rdata_out, 24'h0007, "upper tuning bits");
    chk({20'h0, tune_step_out}, {20'h0, TUNE_MAX}, "maximum step");
    tw(16'hFFF8);
    chk(tune_rdata_out, 24'h0008, "tuning readback");
    chk({20'h0, tune_step_out}, {20'h0, TUNE_MIN}, "minimum step");
    tw(16'h0000);
    chk({20'h0, tune_step_out}, {20'h0, TUNE_CENTRE}, "centre step");
    for (int i = 0; i < CFG_COUNT; i++)
    begin
      cr(CFG_BASE + 24'(2 * i));
      chk(cfg_hit_out, 1'b1, "config hit");
      chk(cfg_rdata_out, {8'h00, CFG_TB[i*24 +: 16]}, "config word");
    end
    cr(CFG_BASE + 24'h1);
    chk(cfg_hit_out, 1'b0, "odd config address hit");
    chk(cfg_rdata_out, 24'h0, "odd config address data");
    cr(CFG_LAST + 24'h2);
    chk(cfg_hit_out, 1'b0, "config past last");
    $display("Test registers done");
    periph_idle_stop_in = 8'hA5;
    fail_safe_clock_monitor_enable_in = 1'b1;
    req(1'b0);
    chk({core_clk_en_out, clk_src_en_out, low_power_rc_oscillator_en_out}, 24'h3, "idle clocks");
    chk(periph_clk_en_out, 24'h5A, "peripheral idle control");
    irq_pending_in = 1'b1;
    tick(2);
    chk({22'h0, state_out}, 24'h2, "masked interrupt");
    irq_enable_in = 1'b1;
    tick(1);
    irq_pending_in = 1'b0;
    chk({state_out, core_clk_en_out, irq_service_out}, 24'h3, "idle wake no delay");
    flags(3'b010);
    req(1'b0);
    {wdt_enable_in, wdt_timeout_in} = 2'b11;
    tick(1);
    wdt_timeout_in = 1'b0;
    chk({22'h0, state_out}, 24'h0, "idle watchdog wake");
    flags(3'b011);
    $display("Test idle done");
    req(1'b1);
    wdt_timeout_in = 1'b1;
    tick(1);
    wdt_timeout_in = 1'b0;
    wait_st(PSWC_RUN);
    tick(3);
    flags(3'b101);
    fail_safe_clock_monitor_enable_in = 1'b0;
    xtal_ok = 1'b0;
    req(1'b1);
    irq_pending_in = 1'b1;
    tick(1);
    irq_pending_in = 1'b0;
    tick(DLY + 4);
    chk({22'h0, state_out}, 24'h3, "held for slow crystal");
    xtal_ok = 1'b1;
    wait_st(PSWC_RUN);
    flags(3'b100);
    fail_safe_clock_monitor_enable_in = 1'b1;
    xtal_ok = 1'b0;
    req(1'b1);
    irq_pending_in = 1'b1;
    tick(1);
    irq_pending_in = 1'b0;
    wait_st(PSWC_RUN);
    chk({clk_fail_trap_out, use_frc_out}, 24'h3, "clock failure trap");
    xtal_ok = 1'b1;
    xtal_reenable_in = 1'b1;
    tick(1);
    xtal_reenable_in = 1'b0;
    chk(use_frc_out, 1'b0, "crystal re-enabled");
    $display("Test sleep done");
    for (int k = 0; k < 4; k++)
    begin
      req(k < 3);
      rst_src = (k < 3) ? 3'(1 << k) : 3'b010;
      tick(1);
      rst_src = 3'b000;
      wait_st(PSWC_RUN);
      chk((k < 3) ? sleep_flag_out : idle_flag_out, 1'b1, "reset wake flag");
    end
    tw(16'h0005);
    por_in = 1'b1;
    tick(1);
    por_in = 1'b0;
    flags(3'b000);
    chk(tune_rdata_out, 24'h0, "power-on clears tuning");
    $display("Test resets done");
    results();
  end
endmodule : power_save_wake_control_tb
